// ---- include/epfdc_pkg.sv ----
// types shared by the emulated phy flow and duplex control
package epfdc_pkg;
  typedef enum logic [1:0] {ST_HOLD, ST_NEG, ST_DONE} epfdc_an_st_t;
  typedef struct packed {
    logic fd100;
    logic hd100;
    logic fd10;
    logic hd10;
  } epfdc_abil_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } epfdc_req_t;
  typedef struct packed {
    logic full_duplex;
    logic speed_100;
    logic tx_pause;
    logic rx_pause;
  } epfdc_port_cfg_t;
  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] pins;
    logic bc_speed;
    logic bc_an_en;
    logic bc_duplex;
    logic bc_reset;
    logic [1:0] adv_pause;
    epfdc_abil_t adv_abil;
    logic [1:0] loc_pause;
    logic [1:0] lp_pause;
    epfdc_abil_t lp_abil;
    logic lp_able;
    logic page_rx;
    logic an_done;
    logic res_full;
    logic res_100;
    epfdc_an_st_t an_st;
    logic [15:0] rst_cnt;
    logic mfc_sel;
    logic mfc_tx;
    logic mfc_rx;
    epfdc_port_cfg_t cfg;
    logic [15:0] rdata;
  } epfdc_state_t;
endpackage : epfdc_pkg

// ---- include/epfdc_regs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef EPFDC_REGS_SVH
`define EPFDC_REGS_SVH
`define EPFDC_ADDR_W 8
`define EPFDC_DATA_W 16
`define EPFDC_BC_ADDR 8'h00
`define EPFDC_BS_ADDR 8'h01
`define EPFDC_ADV_ADDR 8'h04
`define EPFDC_LP_ADDR 8'h05
`define EPFDC_EXP_ADDR 8'h06
`define EPFDC_RST_ADDR 8'h10
`define EPFDC_MFC_ADDR 8'h11
`define EPFDC_BC_RESET 15
`define EPFDC_BC_SPEED 13
`define EPFDC_BC_AN_EN 12
`define EPFDC_BC_RESTART 9
`define EPFDC_BC_DUPLEX 8
`define EPFDC_BS_AN_DONE 5
`define EPFDC_ADV_ASYM 11
`define EPFDC_ADV_SYM 10
`define EPFDC_ADV_ABIL_LSB 5
`define EPFDC_SELECTOR 5'h01
`define EPFDC_EXP_PAGE 1
`define EPFDC_EXP_LP_ABLE 0
`define EPFDC_RST_EMU 1
`define EPFDC_RST_DIGITAL 0
`define EPFDC_MFC_DUP_NOW 6
`define EPFDC_MFC_TX_NOW 5
`define EPFDC_MFC_RX_NOW 4
`define EPFDC_MFC_SEL 3
`define EPFDC_MFC_TX 1
`define EPFDC_MFC_RX 0
`define EPFDC_BC_RST_VAL 3'h7
`define EPFDC_ADV_ABIL_RST 4'hF
`define EPFDC_ADV_PAUSE_RST 2'h3
`define EPFDC_CLK_PERIOD_NS 10
`define EPFDC_EMU_RST_TIME_NS 102000
`define EPFDC_EMU_RST_CYC (`EPFDC_EMU_RST_TIME_NS / `EPFDC_CLK_PERIOD_NS)
`endif

// ---- rtl/epfdc_ctrl.sv ----
// emulated phy pause resolution, port 0 duplex and soft resets
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "epfdc_regs.svh"

module epfdc_ctrl #(
  parameter int unsigned EMU_RST_CYC = `EPFDC_EMU_RST_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire epfdc_pkg::epfdc_req_t req,
  output logic [15:0] rdata,
  input wire logic mac_mode,
  input wire logic eeprom_reload,
  input wire logic port0_duplex_input,
  input wire logic duplex_pol_strap,
  input wire logic speed_strap,
  output logic mdio_access_en,
  output logic emu_phy_in_reset,
  output epfdc_pkg::epfdc_port_cfg_t port0_cfg
);

  // all block state in one record; d is the next value of q
  epfdc_pkg::epfdc_state_t q;
  epfdc_pkg::epfdc_state_t d;

  // filtered pin views: 2 duplex pin, 1 polarity strap, 0 speed strap
  logic dup_in;
  logic dup_pol;
  logic spd_strap;
  assign dup_in = q.pins[2];
  assign dup_pol = q.pins[1];
  assign spd_strap = q.pins[0];

  // emulated partner default abilities from pin and straps
  logic pin_full;
  epfdc_pkg::epfdc_abil_t lp_dflt;
  epfdc_pkg::epfdc_abil_t common;
  assign pin_full = (dup_in == dup_pol);
  assign lp_dflt = '{fd100: spd_strap & pin_full, hd100: spd_strap,
                     fd10: ~spd_strap & pin_full, hd10: ~spd_strap};
  assign common = q.adv_abil & lp_dflt;

  // reset activity and restart sources
  // a restart that meets an active phy reset is dropped: the reset wins
  logic emu_rst;
  logic wr_bc;
  logic wr_adv;
  logic wr_rst;
  logic wr_mfc;
  logic restart;
  assign emu_rst = (q.rst_cnt != 16'h0000) | q.bc_reset;
  assign wr_bc = req.wr & (req.addr == `EPFDC_BC_ADDR);
  assign wr_adv = req.wr & (req.addr == `EPFDC_ADV_ADDR);
  assign wr_rst = req.wr & (req.addr == `EPFDC_RST_ADDR);
  assign wr_mfc = req.wr & (req.addr == `EPFDC_MFC_ADDR);
  assign restart = (wr_bc & req.wdata[`EPFDC_BC_RESTART])
                 | (wr_rst & req.wdata[`EPFDC_RST_DIGITAL])
                 | eeprom_reload;

  // duplex and speed currently in effect
  // mac mode has no negotiation, so with negotiation enabled the pin view is used unlatched; otherwise bc_duplex
  logic eff_full;
  logic eff_100;
  always_comb
  begin
    if (mac_mode)
    begin
      eff_100 = q.bc_speed;
      if (q.bc_an_en)
        eff_full = pin_full;
      else
        eff_full = q.bc_duplex;
    end
    else if (q.bc_an_en)
    begin
      eff_full = q.res_full;
      eff_100 = q.res_100;
    end
    else
    begin
      eff_full = q.bc_duplex;
      eff_100 = q.bc_speed;
    end
  end

  // pause resolution from latched local and partner bits
  // half duplex forces both automatic enables off
  // partner bits mirror the local ones, so only the symmetric bit decides
  logic ls;
  logic la;
  logic ps;
  logic pa;
  logic res_tx;
  logic res_rx;
  logic man;
  assign ls = q.loc_pause[1];
  assign la = q.loc_pause[0];
  assign ps = q.lp_pause[1];
  assign pa = q.lp_pause[0];
  assign res_tx = eff_full & ((ls & ps) | (~ls & la & ps & pa));
  assign res_rx = eff_full & ((ls & ps) | (ls & la & ~ps & pa));
  assign man = ~q.bc_an_en | q.mfc_sel | mac_mode;

  // next state of the whole block
  always_comb
  begin
    d = q;
    d.rdata = 16'h0000;
    // three-stage pin filter, a change counts once stages 2 and 3 agree
    // a glitch shorter than two clocks never reaches the filtered view
    d.sync1 = {port0_duplex_input, duplex_pol_strap, speed_strap};
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    d.pins = (~(q.sync2 ^ q.sync3) & q.sync3) | ((q.sync2 ^ q.sync3) & q.pins);
    d.cfg.full_duplex = eff_full;
    d.cfg.speed_100 = eff_100;
    d.cfg.tx_pause = man ? q.mfc_tx : res_tx;
    d.cfg.rx_pause = man ? q.mfc_rx : res_rx;
    d.bc_reset = 1'b0;
    // reset counter is 16 bits: lengths above 65535 cycles would be cut
    if (q.rst_cnt != 16'h0000)
      d.rst_cnt = q.rst_cnt - 16'h0001;

    // register writes; emulated registers frozen while in reset
    if (wr_bc & ~emu_rst)
    begin
      d.bc_speed = req.wdata[`EPFDC_BC_SPEED];
      d.bc_an_en = req.wdata[`EPFDC_BC_AN_EN];
      d.bc_duplex = req.wdata[`EPFDC_BC_DUPLEX];
      d.bc_reset = req.wdata[`EPFDC_BC_RESET];
    end
    if (wr_adv & ~emu_rst)
    begin
      d.adv_pause = {req.wdata[`EPFDC_ADV_SYM], req.wdata[`EPFDC_ADV_ASYM]};
      d.adv_abil = req.wdata[`EPFDC_ADV_ABIL_LSB +: 4];
    end
    // chip reset bit may land at any time and restarts the count
    if (wr_rst & req.wdata[`EPFDC_RST_EMU])
      d.rst_cnt = EMU_RST_CYC[15:0];
    if (wr_mfc)
    begin
      // only the manual bits change; advertisement left alone
      d.mfc_sel = req.wdata[`EPFDC_MFC_SEL];
      d.mfc_tx = req.wdata[`EPFDC_MFC_TX];
      d.mfc_rx = req.wdata[`EPFDC_MFC_RX];
    end

    // negotiation sequencer
    unique case (q.an_st)
      epfdc_pkg::ST_HOLD:
      begin
        if (~emu_rst)
          d.an_st = epfdc_pkg::ST_NEG;
      end
      // result latched here; advert changes wait for the next restart
      epfdc_pkg::ST_NEG:
      begin
        d.an_st = epfdc_pkg::ST_DONE;
        if (q.bc_an_en)
        begin
          d.an_done = 1'b1;
          d.page_rx = 1'b1;
          d.loc_pause = q.adv_pause;
          d.lp_pause = q.adv_pause;
          if (common != 4'h0)
          begin
            d.lp_able = 1'b1;
            d.lp_abil = lp_dflt;
            d.res_100 = common.fd100 | common.hd100;
            d.res_full = common.fd100 | (~common.hd100 & common.fd10);
          end
          else
          begin
            d.lp_able = 1'b0;
            d.res_full = 1'b0;
            d.res_100 = spd_strap;
            d.lp_abil = '{fd100: 1'b0, hd100: spd_strap,
                          fd10: 1'b0, hd10: ~spd_strap};
          end
        end
      end
      // pin and strap changes alone never restart negotiation
      epfdc_pkg::ST_DONE:
      begin
        if (restart | (wr_bc & req.wdata[`EPFDC_BC_AN_EN] & ~q.bc_an_en))
        begin
          d.an_st = epfdc_pkg::ST_NEG;
          d.an_done = 1'b0;
          d.page_rx = 1'b0;
        end
      end
      // the spare state code falls back to hold
      default:
      begin
        d.an_st = epfdc_pkg::ST_HOLD;
      end
    endcase

    // emulated phy reset puts its registers back to defaults, except the partner page bits (lp_abil, lp_pause)
    if (emu_rst)
    begin
      {d.bc_speed, d.bc_an_en, d.bc_duplex} = `EPFDC_BC_RST_VAL;
      d.adv_abil = `EPFDC_ADV_ABIL_RST;
      d.adv_pause = `EPFDC_ADV_PAUSE_RST;
      d.an_done = 1'b0;
      d.page_rx = 1'b0;
      d.lp_able = 1'b0;
      d.an_st = epfdc_pkg::ST_HOLD;
    end

    // read data, valid in the cycle after the strobe
    // unmapped addresses read as zero
    if (req.rd)
    begin
      unique case (req.addr)
        `EPFDC_BC_ADDR:
        begin
          d.rdata[`EPFDC_BC_RESET] = emu_rst;
          d.rdata[`EPFDC_BC_SPEED] = q.bc_speed;
          d.rdata[`EPFDC_BC_AN_EN] = q.bc_an_en;
          d.rdata[`EPFDC_BC_DUPLEX] = q.bc_duplex;
        end
        `EPFDC_BS_ADDR:
          d.rdata[`EPFDC_BS_AN_DONE] = q.an_done;
        `EPFDC_ADV_ADDR:
        begin
          d.rdata[`EPFDC_ADV_SYM] = q.adv_pause[1];
          d.rdata[`EPFDC_ADV_ASYM] = q.adv_pause[0];
          d.rdata[`EPFDC_ADV_ABIL_LSB +: 4] = q.adv_abil;
          d.rdata[4:0] = `EPFDC_SELECTOR;
        end
        `EPFDC_LP_ADDR:
        begin
          d.rdata[`EPFDC_ADV_SYM] = q.lp_pause[1];
          d.rdata[`EPFDC_ADV_ASYM] = q.lp_pause[0];
          d.rdata[`EPFDC_ADV_ABIL_LSB +: 4] = q.lp_abil;
          d.rdata[4:0] = `EPFDC_SELECTOR;
        end
        `EPFDC_EXP_ADDR:
        begin
          d.rdata[`EPFDC_EXP_PAGE] = q.page_rx;
          d.rdata[`EPFDC_EXP_LP_ABLE] = q.lp_able;
        end
        `EPFDC_RST_ADDR:
          d.rdata[`EPFDC_RST_EMU] = (q.rst_cnt != 16'h0000);
        `EPFDC_MFC_ADDR:
        begin
          d.rdata[`EPFDC_MFC_DUP_NOW] = q.cfg.full_duplex;
          d.rdata[`EPFDC_MFC_TX_NOW] = q.cfg.tx_pause;
          d.rdata[`EPFDC_MFC_RX_NOW] = q.cfg.rx_pause;
          d.rdata[`EPFDC_MFC_SEL] = q.mfc_sel;
          d.rdata[`EPFDC_MFC_TX] = q.mfc_tx;
          d.rdata[`EPFDC_MFC_RX] = q.mfc_rx;
        end
        default:
          d.rdata = 16'h0000;
      endcase
    end
  end

  // state register; power-on and hardware reset start a negotiation
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      {q.bc_speed, q.bc_an_en, q.bc_duplex} <= `EPFDC_BC_RST_VAL;
      q.adv_abil <= `EPFDC_ADV_ABIL_RST;
      q.adv_pause <= `EPFDC_ADV_PAUSE_RST;
      q.an_st <= epfdc_pkg::ST_NEG;
    end
    else
      q <= d;
  end

  // outputs
  // reset flag comes straight from state, so it rises one edge after the write
  assign rdata = q.rdata;
  assign port0_cfg = q.cfg;
  assign emu_phy_in_reset = emu_rst;
  assign mdio_access_en = ~mac_mode;

endmodule : epfdc_ctrl
`default_nettype wire

// ---- tb/epfdc_ctrl_assertions.sv ----
// checker for the emulated phy control ports
`timescale 1ns/10ps
`default_nettype none
`include "epfdc_regs.svh"
module epfdc_ctrl_assertions #(
  parameter int unsigned EMU_RST_CYC = `EPFDC_EMU_RST_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire epfdc_pkg::epfdc_req_t req,
  input wire logic [15:0] rdata,
  input wire logic mac_mode,
  input wire logic mdio_access_en,
  input wire logic emu_phy_in_reset,
  input wire epfdc_pkg::epfdc_port_cfg_t port0_cfg
);
  logic [15:0] cnt_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // length of the current emulated reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 16'h0000;
    else
      cnt_q <= emu_phy_in_reset ? cnt_q + 16'h0001 : 16'h0000;
  end
  a_mdio_mode: assert property (mdio_access_en == !mac_mode)
    else $error("mdio enable wrong");
  a_rdata_idle: assert property (!$past(req.rd) |-> rdata == 16'h0000)
    else $error("read data outside answer cycle");
  a_chip_rst_go: assert property (req.wr && req.addr == 8'h10 && req.wdata[1] |=> emu_phy_in_reset)
    else $error("chip reset bit did not reset");
  a_bc_rst_pulse: assert property (req.wr && req.addr == 8'h00 && req.wdata[15]
    && !emu_phy_in_reset |=> emu_phy_in_reset ##1 !emu_phy_in_reset)
    else $error("basic reset pulse wrong");
  a_rst_cap: assert property (cnt_q <= EMU_RST_CYC)
    else $error("emulated reset too long");
  a_rst_end: assert property ($fell(emu_phy_in_reset) |->
    cnt_q == 16'h0001 || cnt_q == EMU_RST_CYC)
    else $error("emulated reset length wrong");
  a_mfc_view: assert property (req.rd && req.addr == 8'h11 |=> rdata[6:4] ==
    {$past(port0_cfg.full_duplex), $past(port0_cfg.tx_pause), $past(port0_cfg.rx_pause)})
    else $error("manual flow view differs from port");
  a_rst_bit_view: assert property (req.rd && req.addr == 8'h00 |=>
    rdata[15] == $past(emu_phy_in_reset))
    else $error("reset bit view wrong");
endmodule : epfdc_ctrl_assertions
bind epfdc_ctrl epfdc_ctrl_assertions #(.EMU_RST_CYC(EMU_RST_CYC)) u_chk (
  .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .mac_mode(mac_mode),
  .mdio_access_en(mdio_access_en), .emu_phy_in_reset(emu_phy_in_reset),
  .port0_cfg(port0_cfg));
`default_nettype wire

// ---- tb/epfdc_host_model.sv ----
// host management master model on the register port
`timescale 1ns/10ps
`default_nettype none
module epfdc_host_model (
  input wire logic clk,
  output var epfdc_pkg::epfdc_req_t req
);
  initial req = '0;
  // one-cycle strobe, then lines released showing inverted values
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : acc
endmodule : epfdc_host_model
`default_nettype wire

// ---- tb/test_epfdc_ctrl.sv ----
// self-checking bench for the emulated phy flow and duplex control
`timescale 1ns/10ps
`default_nettype none
module test_epfdc_ctrl;
  localparam int unsigned RC = 8;
  logic clk, rst_n, mac_mode, eeprom_reload, pin, pol, spd, mdio_en, in_rst, rd_q;
  logic [15:0] rdata;
  logic [31:0] lf, nt;
  logic [31:0] note_q[$];
  int errors, tests_run;
  epfdc_pkg::epfdc_req_t req;
  epfdc_pkg::epfdc_port_cfg_t cfg;
  epfdc_host_model host (.clk(clk), .req(req));
  epfdc_ctrl #(.EMU_RST_CYC(RC)) DUT (.clk(clk), .rst_n(rst_n), .req(req),
    .rdata(rdata), .mac_mode(mac_mode), .eeprom_reload(eeprom_reload),
    .port0_duplex_input(pin), .duplex_pol_strap(pol), .speed_strap(spd),
    .mdio_access_en(mdio_en), .emu_phy_in_reset(in_rst), .port0_cfg(cfg));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.acc(1'b1, a, d);
  endtask : wr
  // note the masked expectation, then issue the read
  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    note_q.push_back({m, e});
    host.acc(1'b0, a, 16'h0000);
  endtask : rd
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w
  task automatic complete_run;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog
  initial
  begin
    #200000;
    errors++;
    complete_run();
  end
  // compare each read answer with the oldest note
  always @(posedge clk)
  begin
    rd_q <= req.rd;
    if (rd_q === 1'b1)
    begin
      nt = note_q.pop_front();
      chk(rdata & nt[31:16], nt[15:0]);
    end
  end
  initial
  begin
    rst_n = 1'b0;
    mac_mode = 1'b0;
    eeprom_reload = 1'b0;
    pin = 1'b1;
    pol = 1'b1;
    spd = 1'b1;
    lf = 32'h3c2c;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h04, 16'hFFFF, 16'h0DE1);
    chk({15'h0000, mdio_en}, 16'h0001);
    // every pause code, partner mirrors it
    for (int p = 0; p < 4; p++)
    begin
      wr(8'h04, {4'h0, p[1:0], 10'h1E1});
      wr(8'h00, 16'h3300);
      w(4);
      chk({12'h000, cfg}, {14'h0003, p[0], p[0]});
      rd(8'h05, 16'h0C00, {4'h0, p[1:0], 10'h000});
    end
    // manual override with random enables, advert untouched
    for (int i = 0; i < 3; i++)
    begin
      lf = lfsr(lf);
      wr(8'h11, {12'h000, 2'h2, lf[1:0]});
      w(3);
      chk({12'h000, cfg}, {14'h0003, lf[1:0]});
      rd(8'h11, 16'h007B, {9'h000, 1'b1, lf[1:0], 2'h2, lf[1:0]});
      rd(8'h04, 16'hFFFF, 16'h0DE1);
    end
    // no common ability: half duplex at strap speed
    wr(8'h11, 16'h0000);
    wr(8'h04, 16'h0C01);
    wr(8'h10, 16'h0001);
    w(4);
    chk({12'h000, cfg}, 16'h0004);
    rd(8'h06, 16'h0001, 16'h0000);
    rd(8'h05, 16'h01E0, 16'h0080);
    // same with the speed strap low: 10 half, one 10 bit in partner
    @(posedge clk);
    spd <= 1'b0;
    w(6);
    wr(8'h00, 16'h3300);
    w(4);
    chk({12'h000, cfg}, 16'h0000);
    rd(8'h05, 16'h01E0, 16'h0020);
    @(posedge clk);
    spd <= 1'b1;
    w(6);
    // negotiation off forces speed and duplex
    wr(8'h00, 16'h0000);
    w(3);
    chk({12'h000, cfg}, 16'h0000);
    wr(8'h00, 16'h2100);
    w(3);
    chk({12'h000, cfg}, 16'h000C);
    // mac mode duplex tracks pin against strap
    @(posedge clk);
    mac_mode <= 1'b1;
    wr(8'h00, 16'h3000);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      pin <= i[0];
      pol <= i[1];
      w(8);
      chk({15'h0000, cfg.full_duplex}, {15'h0000, i[0] == i[1]});
    end
    // host sets pause by hand; mac mode always takes the manual bits
    wr(8'h11, 16'h0002);
    w(3);
    chk({12'h000, cfg}, 16'h000E);
    chk({15'h0000, mdio_en}, 16'h0000);
    wr(8'h00, 16'h2100);
    w(3);
    chk({15'h0000, cfg.full_duplex}, 16'h0001);
    wr(8'h00, 16'h2000);
    w(3);
    chk({15'h0000, cfg.full_duplex}, 16'h0000);
    @(posedge clk);
    mac_mode <= 1'b0;
    // chip reset bit self-clears after its count
    wr(8'h10, 16'h0002);
    rd(8'h10, 16'h0002, 16'h0002);
    for (int i = 0; i < 100 && in_rst === 1'b1; i++)
      @(posedge clk);
    rd(8'h10, 16'h0002, 16'h0000);
    wr(8'h00, 16'hB100);
    w(3);
    rd(8'h00, 16'h8000, 16'h0000);
    // advert change waits for a restart; the reload pulse gives one
    wr(8'h04, 16'h0C81);
    w(2);
    chk({12'h000, cfg}, 16'h000F);
    @(posedge clk);
    eeprom_reload <= 1'b1;
    @(posedge clk);
    eeprom_reload <= 1'b0;
    w(4);
    chk({12'h000, cfg}, 16'h0004);
    rd(8'h01, 16'h0020, 16'h0020);
    rd(8'h02, 16'hFFFF, 16'h0000);
    w(4);
    complete_run();
  end
endmodule : test_epfdc_ctrl
`default_nettype wire
